/* File: hw/exc_regs_pkg.sv */
// Package: register map, field positions and constants of the exception state block
package exc_regs_pkg;
  // ===========================================================================
  // Register map (word index = byte address / 4)
  localparam int          IDX_W            = 10;
  localparam logic [9:0]  IDX_INT_CTRL     = 10'h001;
  localparam logic [9:0]  IDX_VECT_BASE    = 10'h002;
  localparam logic [9:0]  IDX_APP_CTRL     = 10'h003;
  localparam int          ADDR_IDX_LSB     = 2;
  localparam int          ADDR_IDX_MSB     = 11;
  // ===========================================================================
  // Interrupt control and state fields
  localparam int          DEF_SET_BIT      = 28;
  localparam int          DEF_CLR_BIT      = 27;
  localparam int          TICK_SET_BIT     = 26;
  localparam int          TICK_CLR_BIT     = 25;
  localparam int          DEBUG_BIT        = 23;
  localparam int          IRQ_PEND_BIT     = 22;
  localparam int          TOP_MSB          = 17;
  localparam int          TOP_LSB          = 12;
  localparam int          SINGLE_BIT       = 11;
  localparam int          ACTIVE_MSB       = 8;
  localparam int          ACTIVE_LSB       = 0;
  // ===========================================================================
  // Vector table base fields
  localparam logic [31:0] VTB_WRITE_MASK   = 32'h3FFF_FF80;
  localparam logic [31:0] VTB_RESET        = 32'h0000_0000;
  // ===========================================================================
  // Application control key
  localparam logic [15:0] APP_WRITE_KEY    = 16'h05FA;
  localparam logic [15:0] APP_READ_KEY     = 16'hFA05;
  localparam int          KEY_MSB          = 31;
  localparam int          KEY_LSB          = 16;
  // ===========================================================================
  // Exceptions
  localparam int          NUM_IRQ          = 32;
  localparam int          PRIO_W           = 8;
  localparam int          NUM_W            = 6;
  localparam logic [5:0]  EXC_DEFERRED     = 6'h0E;
  localparam logic [5:0]  EXC_TICK         = 6'h0F;
  localparam logic [5:0]  EXC_IRQ_BASE     = 6'h10;
  localparam logic [5:0]  ACTIVE_ONE       = 6'h01;
  localparam logic [31:0] WORD_ZERO        = 32'h0000_0000;
endpackage

/* File: hw/reg_access_if.sv */
// Interface: register access strobes between the bus port and the register core
`timescale 1ns/1ps
interface reg_access_if;
  import exc_regs_pkg::*;
  logic             wr_en;
  logic             rd_en;
  logic [IDX_W-1:0] idx;
  logic [31:0]      wdata;
  logic [31:0]      rdata;
  modport port (output wr_en, output rd_en, output idx, output wdata, input rdata);
  modport regs (input wr_en, input rd_en, input idx, input wdata, output rdata);
endinterface

/* File: hw/ahb_reg_port.sv */
// AHB-Lite slave front end: one wait state on reads, none on writes
`timescale 1ns/1ps
module ahb_reg_port
  import exc_regs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  reg_access_if.port       bus
);
  typedef struct packed {
    logic             wr_pend;
    logic             rd_pend;
    logic [IDX_W-1:0] idx;
    logic [31:0]      hrdata;
    logic             hreadyout;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;
  logic        accept;

  assign accept    = hsel & htrans[1] & hready;
  assign bus.wr_en = s.wr_pend;
  assign bus.rd_en = s.rd_pend;
  assign bus.idx   = s.idx;
  assign bus.wdata = hwdata;
  assign hrdata    = s.hrdata;
  assign hreadyout = s.hreadyout;

  always_comb begin
    next_s = s;
    if (s.wr_pend) begin
      next_s.wr_pend = 1'b0;
    end
    // Read data is sampled in the wait cycle, after any earlier write landed
    if (s.rd_pend) begin
      next_s.rd_pend   = 1'b0;
      next_s.hrdata    = bus.rdata;
      next_s.hreadyout = 1'b1;
    end
    if (accept) begin
      next_s.idx = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
      end else begin
        next_s.rd_pend   = 1'b1;
        next_s.hreadyout = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{wr_pend: 1'b0, rd_pend: 1'b0, idx: '0, hrdata: WORD_ZERO, hreadyout: 1'b1};
    end else begin
      s <= next_s;
    end
  end
endmodule

/* File: hw/pending_resolver.sv */
// Highest-priority pending enabled exception, after base priority and fault masking
`timescale 1ns/1ps
module pending_resolver
  import exc_regs_pkg::*;
(
  input  wire logic [NUM_IRQ-1:0]        irq_pending,
  input  wire logic [NUM_IRQ-1:0]        irq_enable,
  input  wire logic [NUM_IRQ*PRIO_W-1:0] irq_priority,
  input  wire logic                      tick_pending,
  input  wire logic [PRIO_W-1:0]         tick_priority,
  input  wire logic                      deferred_pending,
  input  wire logic [PRIO_W-1:0]         deferred_priority,
  input  wire logic [PRIO_W-1:0]         base_priority_mask,
  input  wire logic                      fault_mask,
  output logic      [NUM_W-1:0]          top_number
);
  logic              found;
  logic [PRIO_W-1:0] best_prio;

  // Masked candidates are dropped; the general priority mask is not an input
  function automatic logic eligible(input logic pend, input logic [PRIO_W-1:0] prio);
    eligible = pend & ~fault_mask & ((base_priority_mask == '0) | (prio < base_priority_mask));
  endfunction

  always_comb begin
    found      = 1'b0;
    best_prio  = '0;
    top_number = '0;
    // Lower priority value wins; on a tie the lower exception number wins
    if (eligible(deferred_pending, deferred_priority)) begin
      found      = 1'b1;
      best_prio  = deferred_priority;
      top_number = EXC_DEFERRED;
    end
    if (eligible(tick_pending, tick_priority) && (!found || tick_priority < best_prio)) begin
      found      = 1'b1;
      best_prio  = tick_priority;
      top_number = EXC_TICK;
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (eligible(irq_pending[i] & irq_enable[i], irq_priority[i*PRIO_W +: PRIO_W]) &&
          (!found || irq_priority[i*PRIO_W +: PRIO_W] < best_prio)) begin
        found      = 1'b1;
        best_prio  = irq_priority[i*PRIO_W +: PRIO_W];
        top_number = EXC_IRQ_BASE + NUM_W'(i);
      end
    end
  end
endmodule

/* File: hw/exception_state_vector_regs.sv */
// Exception state, vector table base and keyed reset-control write gate on AHB-Lite
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Writing 1 to bit 25 clears tick pending; 0 leaves it.
// - Bit 25 is write-only; its read value must not be relied on.
// - Bit 23 reads zero whenever the core is not halted in debug.
// - Bit 22 shows any pending interrupt, excluding NMI and faults.
// - Bits 17:12 give highest-priority pending enabled exception, zero if none.
// - That number honours base priority and fault masks, not general mask.
// - Bit 11 is 0 with preempted actives, 1 with none or one active.
// - Bits 8:0 read zero in thread mode, else the active exception number.
// - Active number always equals status register exception field bits 8:0.
// - Table base field bits 29:7 hold offset bits 29:7.
// - Offset bit 29 picks code region (0) or SRAM region (1).
// - Table base bits 6:0 are reserved, never stored.
// - Reset-control writes without key 0x5FA are discarded.
// - Writing 1 to bit 28 sets deferred-call pending; reads show the state.
// - Writing 1 to bit 27 clears deferred-call pending; 0 has no effect.
// - Writing 1 to bit 26 sets tick pending; reads show the state.
module exception_state_vector_regs
  import exc_regs_pkg::*;
(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic                      hready,
  input  wire logic [31:0]               hwdata,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // Core exception state
  input  wire logic [NUM_IRQ-1:0]        irq_pending,
  input  wire logic [NUM_IRQ-1:0]        irq_enable,
  input  wire logic [NUM_IRQ*PRIO_W-1:0] irq_priority,
  input  wire logic [PRIO_W-1:0]         tick_priority,
  input  wire logic [PRIO_W-1:0]         deferred_priority,
  input  wire logic [PRIO_W-1:0]         base_priority_mask,
  input  wire logic                      fault_mask,
  input  wire logic [8:0]                status_exception_field,
  input  wire logic [NUM_W-1:0]          active_count,
  input  wire logic                      debug_halted,
  input  wire logic                      debug_pending_flag,
  // Tick timer and exception entry
  input  wire logic                      tick_event,
  input  wire logic                      tick_taken,
  input  wire logic                      deferred_taken,
  // Results
  output logic                           tick_pending,
  output logic                           deferred_pending,
  output logic      [31:0]               vector_table_base,
  output logic                           app_ctrl_write,
  output logic      [15:0]               app_ctrl_data
);
  // ===========================================================================
  // State
  typedef struct packed {
    logic        tick_pending;
    logic        deferred_pending;
    logic [31:0] vector_table_base;
    logic        app_ctrl_write;
    logic [15:0] app_ctrl_data;
    logic        hresp;
  } core_state_t;

  core_state_t      s;
  core_state_t      next_s;
  reg_access_if     acc ();
  logic [NUM_W-1:0] top_pending_number;
  logic             irq_pending_flag;
  logic             single_active_flag;
  logic [8:0]       active_exception_number;
  logic             debug_flag;
  logic [31:0]      interrupt_control_state;
  logic             ctrl_hit;
  logic             vtb_hit;
  logic             app_hit;

  assign tick_pending      = s.tick_pending;
  assign deferred_pending  = s.deferred_pending;
  assign vector_table_base = s.vector_table_base;
  assign app_ctrl_write    = s.app_ctrl_write;
  assign app_ctrl_data     = s.app_ctrl_data;
  assign hresp             = s.hresp;

  // ===========================================================================
  // Bus front end
  ahb_reg_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .bus       (acc.port)
  );

  // ===========================================================================
  // Pending resolution
  // highest pending number
  pending_resolver u_resolver (
    .irq_pending        (irq_pending),
    .irq_enable         (irq_enable),
    .irq_priority       (irq_priority),
    .tick_pending       (s.tick_pending),
    .tick_priority      (tick_priority),
    .deferred_pending   (s.deferred_pending),
    .deferred_priority  (deferred_priority),
    .base_priority_mask (base_priority_mask),
    .fault_mask         (fault_mask),
    .top_number         (top_pending_number)
  );

  // ===========================================================================
  // Status decoding
  // external interrupts only
  assign irq_pending_flag   = |irq_pending;
  assign single_active_flag = (active_count <= ACTIVE_ONE);
  // mirror of status field, zero in thread mode
  assign active_exception_number = status_exception_field;
  assign debug_flag         = debug_halted & debug_pending_flag;

  // Read image: write-only and reserved positions stay zero
  always_comb begin
    interrupt_control_state                        = WORD_ZERO;
    interrupt_control_state[DEF_SET_BIT]           = s.deferred_pending;
    interrupt_control_state[TICK_SET_BIT]          = s.tick_pending;
    interrupt_control_state[DEBUG_BIT]             = debug_flag;
    interrupt_control_state[IRQ_PEND_BIT]          = irq_pending_flag;
    interrupt_control_state[TOP_MSB:TOP_LSB]       = top_pending_number;
    interrupt_control_state[SINGLE_BIT]            = single_active_flag;
    interrupt_control_state[ACTIVE_MSB:ACTIVE_LSB] = active_exception_number;
  end

  // ===========================================================================
  // Address decode and read mux
  assign ctrl_hit = (acc.idx == IDX_INT_CTRL);
  assign vtb_hit  = (acc.idx == IDX_VECT_BASE);
  assign app_hit  = (acc.idx == IDX_APP_CTRL);

  always_comb begin
    if (ctrl_hit) begin
      acc.rdata = interrupt_control_state;
    end else if (vtb_hit) begin
      acc.rdata = s.vector_table_base;
    end else if (app_hit) begin
      acc.rdata = {APP_READ_KEY, 16'h0000};
    end else begin
      acc.rdata = WORD_ZERO;
    end
  end

  // ===========================================================================
  // Next state
  always_comb begin
    next_s                = s;
    next_s.app_ctrl_write = 1'b0;
    next_s.hresp          = 1'b0;
    // Hardware sets and clears; a set in the same cycle as a clear wins
    if (tick_taken) begin
      next_s.tick_pending = 1'b0;
    end
    if (deferred_taken) begin
      next_s.deferred_pending = 1'b0;
    end
    if (acc.wr_en && ctrl_hit) begin
      if (acc.wdata[TICK_CLR_BIT]) begin
        next_s.tick_pending = 1'b0;
      end
      if (acc.wdata[DEF_CLR_BIT]) begin
        next_s.deferred_pending = 1'b0;
      end
      if (acc.wdata[TICK_SET_BIT]) begin
        next_s.tick_pending = 1'b1;
      end
      if (acc.wdata[DEF_SET_BIT]) begin
        next_s.deferred_pending = 1'b1;
      end
    end
    if (tick_event) begin
      next_s.tick_pending = 1'b1;
    end
    if (acc.wr_en && vtb_hit) begin
      next_s.vector_table_base = acc.wdata & VTB_WRITE_MASK;
    end
    if (acc.wr_en && app_hit && acc.wdata[KEY_MSB:KEY_LSB] == APP_WRITE_KEY) begin
      next_s.app_ctrl_write = 1'b1;
      next_s.app_ctrl_data  = acc.wdata[KEY_LSB-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{tick_pending: 1'b0, deferred_pending: 1'b0, vector_table_base: VTB_RESET,
             app_ctrl_write: 1'b0, app_ctrl_data: 16'h0000, hresp: 1'b0};
    end else begin
      s <= next_s;
    end
  end
endmodule

/* File: verif/exc_state_assertions.sv */
// Checker: bus timing and register behaviour seen at the block's ports
`timescale 1ns/1ps
module exc_state_assertions
  import exc_regs_pkg::*;
(
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [31:0]      hwdata,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      irq_pending,
  input wire logic [8:0]       status_exception_field,
  input wire logic [NUM_W-1:0] active_count,
  input wire logic             debug_halted,
  input wire logic             debug_pending_flag,
  input wire logic             tick_event,
  input wire logic             tick_pending,
  input wire logic             deferred_pending,
  input wire logic [31:0]      vector_table_base,
  input wire logic             app_ctrl_write,
  input wire logic [15:0]      app_ctrl_data
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================================
  // Transfer steps
  sequence take_s(w, i);
    hsel && htrans[1] && hready && hwrite == w && haddr[ADDR_IDX_MSB:ADDR_IDX_LSB] == i;
  endsequence
  sequence ctrl_rd_s;
    take_s(1'b0, IDX_INT_CTRL) ##1 !hreadyout ##1 hreadyout;
  endsequence
  sequence wr_s(i);
    take_s(1'b1, i) ##1 hreadyout;
  endsequence
  // ==========================================================================
  // Properties
  read_wait_a: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
  active_copy_a: assert property (ctrl_rd_s |->
    hrdata[8:0] == $past(status_exception_field)) else $error("active number wrong");
  status_flags_a: assert property (ctrl_rd_s |->
    hrdata[23] == $past(debug_halted && debug_pending_flag) && hrdata[22] == |$past(irq_pending)
    && hrdata[11] == ($past(active_count) <= 6'h01)) else $error("status flag wrong");
  ctrl_resv_a: assert property (ctrl_rd_s |->
    hrdata[31:29] == 3'h0 && !hrdata[24] && hrdata[21:18] == 4'h0 && hrdata[10:9] == 2'h0)
    else $error("reserved bit set");
  tick_set_a: assert property (wr_s(IDX_INT_CTRL) ##0 hwdata[26] |=> tick_pending)
    else $error("tick not pending");
  tick_clr_a: assert property (
    wr_s(IDX_INT_CTRL) ##0 (hwdata[25] && !hwdata[26] && !tick_event) |=> !tick_pending)
    else $error("tick still pending");
  def_set_a: assert property (wr_s(IDX_INT_CTRL) ##0 hwdata[28] |=> deferred_pending)
    else $error("deferred not pending");
  def_clr_a: assert property (
    wr_s(IDX_INT_CTRL) ##0 (hwdata[27] && !hwdata[28]) |=> !deferred_pending)
    else $error("deferred still pending");
  key_drop_a: assert property (
    wr_s(IDX_APP_CTRL) ##0 hwdata[31:16] != APP_WRITE_KEY |=> !app_ctrl_write)
    else $error("unkeyed write taken");
  key_take_a: assert property (
    wr_s(IDX_APP_CTRL) ##0 hwdata[31:16] == APP_WRITE_KEY |=>
    app_ctrl_write && app_ctrl_data == $past(hwdata[15:0])) else $error("keyed write lost");
  vtb_store_a: assert property (wr_s(IDX_VECT_BASE) |=>
    vector_table_base == ($past(hwdata) & VTB_WRITE_MASK)) else $error("table base wrong");
endmodule

/* File: verif/test_exception_state_vector_regs.sv */
// Testbench: random and corner register traffic for the exception state block
`timescale 1ns/1ps
module test_exception_state_vector_regs
  import exc_regs_pkg::*;
;
  localparam logic [31:0] A_CTRL = 32'h0000_0004, A_VTB = 32'h0000_0008, A_APP = 32'h0000_000C;
  logic                      hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic                      fault_mask = 1'b0, debug_halted = 1'b0, debug_pending_flag = 1'b0;
  logic                      tick_event = 1'b0, tick_taken = 1'b0, deferred_taken = 1'b0;
  logic                      hresp, hreadyout, tick_pending, deferred_pending, app_ctrl_write;
  logic                      tick_p = 1'b0, def_p = 1'b0;
  logic [1:0]                htrans = 2'h0;
  logic [2:0]                hsize = 3'h2;
  logic [8:0]                status_exception_field = 9'h000;
  logic [15:0]               app_ctrl_data, app_last = 16'h0000;
  logic [31:0]               haddr = '0, hwdata = '0, irq_pending = '0, irq_enable = '0;
  logic [31:0]               hrdata, vector_table_base, rd, d;
  logic [NUM_W-1:0]          active_count = '0;
  logic [PRIO_W-1:0]         tick_priority = '0, deferred_priority = '0, base_priority_mask = '0;
  logic [NUM_IRQ*PRIO_W-1:0] irq_priority = '0;
  int                        bad_count = 0, compares = 0;

  exception_state_vector_regs u_dut (.hready(hreadyout), .*);

  always #5 hclk = ~hclk;

  // ==========================================================================
  // Reporting
  task automatic wrap_up;
    $display("counts: compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    compares++;
    if ((got & m) !== (exp & m)) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ==========================================================================
  // Bus master
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  // ==========================================================================
  // Expectations
  function automatic logic [5:0] top_num();
    logic [8:0] best;
    logic [7:0] p;
    logic       c;
    logic [5:0] n;
    best = 9'h100;
    n = 6'h00;
    for (int k = 14; k < 48; k++) begin
      if (k == 14) begin
        c = def_p;
        p = deferred_priority;
      end else if (k == 15) begin
        c = tick_p;
        p = tick_priority;
      end else begin
        c = irq_pending[k-16] && irq_enable[k-16];
        p = irq_priority[8*(k-16) +: 8];
      end
      if (c && (base_priority_mask == 8'h00 || p < base_priority_mask) && {1'b0, p} < best) begin
        best = {1'b0, p};
        n = 6'(k);
      end
    end
    return fault_mask ? 6'h00 : n;
  endfunction
  function automatic logic [31:0] exp_ctrl();
    logic [31:0] e;
    e = {3'h0, def_p, 1'b0, tick_p, 2'h0, debug_halted && debug_pending_flag, |irq_pending,
         4'h0, top_num(), active_count <= 6'h01, 2'h0, status_exception_field};
    return e;
  endfunction
  task automatic ctrl_check;
    bus(1'b0, A_CTRL, '0);
    check(rd, exp_ctrl(), 32'hF5FF_FFFF);
    check({tick_pending, deferred_pending}, {tick_p, def_p}, '1);
  endtask
  task automatic rand_core;
    irq_pending <= $urandom & $urandom;
    irq_enable <= $urandom;
    for (int k = 0; k < NUM_IRQ; k++) irq_priority[8*k +: 8] <= 8'($urandom_range(0, 15));
    tick_priority <= 8'($urandom_range(0, 15));
    deferred_priority <= 8'($urandom_range(0, 15));
    base_priority_mask <= ($urandom_range(0, 2) == 0) ? 8'h00 : 8'($urandom_range(1, 16));
    fault_mask <= ($urandom_range(0, 3) == 0);
    status_exception_field <= 9'($urandom_range(0, 47));
    active_count <= 6'($urandom_range(0, 3));
    debug_halted <= 1'($urandom);
    debug_pending_flag <= 1'($urandom);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'hFEBA9850));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, A_VTB, '0);
    check(rd, VTB_RESET, '1);
    bus(1'b0, A_APP, '0);
    check(rd, {APP_READ_KEY, 16'h0000}, '1);
    bus(1'b1, 32'h0000_0040, '1);
    bus(1'b0, 32'h0000_0040, '0);
    check(rd, WORD_ZERO, '1);
    ctrl_check();
    $display("test reset_values done");
    for (int it = 0; it < 40; it++) begin
      rand_core();
      d = $urandom;
      if (d[28]) d[27] = 1'b0;
      if (d[26]) d[25] = 1'b0;
      bus(1'b1, A_CTRL, d);
      def_p = d[28] | (def_p & ~d[27]);
      tick_p = d[26] | (tick_p & ~d[25]);
      ctrl_check();
      d = $urandom;
      if (it % 2 == 0) d[7:0] = 8'h00;
      bus(1'b1, A_VTB, d);
      bus(1'b0, A_VTB, '0);
      check(rd, d & VTB_WRITE_MASK, '1);
      d = $urandom;
      if (it % 2 == 1) d[31:16] = APP_WRITE_KEY;
      else d[31] = 1'b1;
      bus(1'b1, A_APP, d);
      @(posedge hclk);
      if (it % 2 == 1) app_last = d[15:0];
      check({app_ctrl_write, app_ctrl_data}, {it % 2 == 1, app_last}, '1);
    end
    $display("test random_traffic done");
    bus(1'b1, A_CTRL, 32'h0A00_0000);
    tick_event <= 1'b1;
    tick_taken <= 1'b1;
    @(posedge hclk);
    tick_event <= 1'b0;
    @(posedge hclk);
    check(tick_pending, 1'b1, '1);
    tick_taken <= 1'b0;
    @(posedge hclk);
    check(tick_pending, 1'b0, '1);
    bus(1'b1, A_CTRL, 32'h1000_0000);
    deferred_taken <= 1'b1;
    @(posedge hclk);
    deferred_taken <= 1'b0;
    @(posedge hclk);
    check(deferred_pending, 1'b0, '1);
    $display("test strobes done");
    irq_pending <= '1;
    irq_enable <= '1;
    irq_priority <= {NUM_IRQ{8'h40}};
    tick_priority <= 8'h40;
    deferred_priority <= 8'h40;
    fault_mask <= 1'b0;
    bus(1'b1, A_CTRL, 32'h1400_0000);
    def_p = 1'b1;
    tick_p = 1'b1;
    foreach (d[k]) if (k < 3) begin
      base_priority_mask <= (k == 0) ? 8'h40 : (k == 1) ? 8'h41 : 8'h00;
      ctrl_check();
    end
    $display("test priority_ties done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    check(vector_table_base, VTB_RESET, '1);
    check({hreadyout, tick_pending, deferred_pending, app_ctrl_write}, 4'h8, '1);
    hresetn <= 1'b1;
    @(posedge hclk);
    tick_p = 1'b0;
    def_p = 1'b0;
    ctrl_check();
    $display("test mid_reset done");
    wrap_up();
  end
endmodule

bind exception_state_vector_regs exc_state_assertions u_chk (.*);
